/* File: hdl/csscr_regs.sv */
// Assumes the core presents one register access per enabled cycle.
`default_nettype none
module csscr_regs #(
  parameter int ACC_WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire csscr_pkg::csscr_bus_t i_bus,
  input wire csscr_pkg::csscr_alu_t i_alu,
  input wire csscr_pkg::csscr_stk_t i_stk,
  input wire logic [ACC_WIDTH-1:0] i_acc,
  output logic [7:0] o_rdata,
  output csscr_pkg::csscr_cfg_t o_cfg,
  output logic o_violation_irq,
  output logic o_violation_rst
);
  import csscr_pkg::*;

  typedef struct packed {
    logic [7:0] program_status_word;
    logic [7:0] program_control;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] spl;
    logic [7:0] stack_pointer_high;
    logic [7:0] sbc;
    logic [7:0] cfg;
    logic [7:0] rdata;
    csscr_cfg_t out;
    logic irq;
    logic rst;
  } csscr_state_t;

  csscr_state_t st;
  csscr_state_t next_st;
  logic parity;
  logic below_start;
  logic at_water;
  logic [10:0] cand;
  logic cand_valid;
  logic [10:0] cur_sp;
  logic [10:0] start_addr;

  // ==========================================================
  // Helpers
  csscr_parity #(
    .WIDTH(ACC_WIDTH)
  ) u_parity (
    .i_data(i_acc),
    .o_parity(parity)
  );

  csscr_stack_guard u_guard (
    .i_candidate(cand),
    .i_start_bits(st.stack_pointer_high[SPH_START_HI:SPH_START_LO]),
    .i_water_setting(st.sbc[SBC_WATER_HI:SBC_WATER_LO]),
    .o_below_start(below_start),
    .o_at_waterline(at_water)
  );

  function automatic logic [7:0] read_reg(input csscr_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_STACK_POINTER_LOW: v = s.spl;
      ADDR_DATA_POINTER_LOW: v = s.data_pointer_low;
      ADDR_DATA_POINTER_HIGH: v = s.data_pointer_high;
      ADDR_PROGRAM_CONTROL: v = s.program_control;
      ADDR_CORE_CONFIGURATION: v = s.cfg;
      ADDR_STACK_POINTER_HIGH: v = s.stack_pointer_high;
      ADDR_STACK_BOUNDARY_CONTROL: v = s.sbc;
      ADDR_PROGRAM_STATUS_WORD: v = s.program_status_word;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign cur_sp = {st.stack_pointer_high[SPH_ADDR_HI:0], st.spl};
  assign start_addr = {st.stack_pointer_high[SPH_START_HI:SPH_START_LO], 8'h00};

  // ==========================================================
  // Candidate stack pointer
  always_comb
  begin
    cand = cur_sp;
    cand_valid = 1'b0;
    if (i_bus.wr && i_bus.addr == ADDR_STACK_POINTER_LOW)
    begin
      cand = {cur_sp[10:8], i_bus.wdata};
      cand_valid = 1'b1;
    end
    else if (i_bus.wr && i_bus.addr == ADDR_STACK_POINTER_HIGH)
    begin
      cand = {i_bus.wdata[SPH_ADDR_HI:0], cur_sp[7:0]};
      cand_valid = 1'b1;
    end
    else if (i_stk.push && !i_bus.wr)
    begin
      // Overflow past top wraps to start
      cand = (cur_sp == STACK_TOP) ? start_addr : 11'(cur_sp + 11'h001);
      cand_valid = 1'b1;
    end
    else if (i_stk.pop && !i_bus.wr)
    begin
      cand = 11'(cur_sp - 11'h001);
      cand_valid = 1'b1;
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    logic bottom_hit;
    logic water_hit;
    logic prot;
    logic [7:0] new_sph;
    bottom_hit = 1'b0;
    water_hit = 1'b0;
    prot = 1'b0;
    new_sph = 8'h00;
    next_st = st;
    prot = st.sbc[SBC_PROTECT_EN];
    bottom_hit = prot && cand_valid && below_start;
    water_hit = prot && cand_valid && at_water && !bottom_hit;
    // Register writes
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        ADDR_PROGRAM_STATUS_WORD: next_st.program_status_word[7:1] = i_bus.wdata[7:1];
        ADDR_PROGRAM_CONTROL: next_st.program_control = i_bus.wdata;
        ADDR_DATA_POINTER_LOW: next_st.data_pointer_low = i_bus.wdata;
        ADDR_DATA_POINTER_HIGH: next_st.data_pointer_high = i_bus.wdata;
        ADDR_STACK_POINTER_LOW:
        begin
          if (!bottom_hit)
          begin
            next_st.spl = i_bus.wdata;
          end
        end
        ADDR_STACK_POINTER_HIGH:
        begin
          new_sph = i_bus.wdata;
          // Flag is sticky: writing one does not set it
          new_sph[SPH_BOTTOM_FLAG] = i_bus.wdata[SPH_BOTTOM_FLAG] &
            st.stack_pointer_high[SPH_BOTTOM_FLAG];
          if (bottom_hit)
          begin
            new_sph[SPH_ADDR_HI:0] = st.stack_pointer_high[SPH_ADDR_HI:0];
          end
          next_st.stack_pointer_high = new_sph;
        end
        ADDR_STACK_BOUNDARY_CONTROL:
        begin
          next_st.sbc[7:1] = i_bus.wdata[7:1];
          next_st.sbc[SBC_WATER_FLAG] = i_bus.wdata[SBC_WATER_FLAG] &
            st.sbc[SBC_WATER_FLAG];
        end
        ADDR_CORE_CONFIGURATION: next_st.cfg = i_bus.wdata;
        default: next_st.cfg = next_st.cfg;
      endcase
    end
    else if (cand_valid && !bottom_hit)
    begin
      next_st.spl = cand[7:0];
      next_st.stack_pointer_high[SPH_ADDR_HI:0] = cand[10:8];
    end
    // Arithmetic flags from the core
    case (i_alu.op)
      CSSCR_OP_ADD, CSSCR_OP_ADDC:
      begin
        next_st.program_status_word[PSW_CARRY] = i_alu.carry;
        next_st.program_status_word[PSW_AUX_CARRY] = i_alu.aux_carry;
        next_st.program_status_word[PSW_OVERFLOW] = i_alu.overflow;
      end
      CSSCR_OP_SUBB, CSSCR_OP_MUL, CSSCR_OP_DIV:
      begin
        next_st.program_status_word[PSW_CARRY] = i_alu.carry;
        next_st.program_status_word[PSW_OVERFLOW] = i_alu.overflow;
      end
      default: next_st.program_status_word = next_st.program_status_word;
    endcase
    next_st.program_status_word[PSW_PARITY] = parity;
    // Sticky flags: set wins over clear
    if (bottom_hit)
    begin
      next_st.stack_pointer_high[SPH_BOTTOM_FLAG] = 1'b1;
    end
    if (water_hit)
    begin
      next_st.sbc[SBC_WATER_FLAG] = 1'b1;
    end
    // Violation response
    next_st.irq = (bottom_hit || water_hit) && !st.sbc[SBC_INT_RESET_SEL];
    next_st.rst = (bottom_hit || water_hit) && st.sbc[SBC_INT_RESET_SEL];
    // Outputs
    next_st.rdata = read_reg(next_st, i_bus.addr);
    next_st.out.baud_doubler = next_st.program_control[PROGRAM_CONTROL_BAUD_DOUBLER];
    next_st.out.enhanced_uart_enable = next_st.cfg[CFG_ENH_UART];
    next_st.out.shared_serial_select = next_st.cfg[CFG_SHARED_SERIAL];
    next_st.out.carrier_modulation_enable = next_st.cfg[CFG_CARRIER_MOD];
    next_st.out.xram_access_enable = next_st.cfg[CFG_XRAM_HI] |
      next_st.cfg[CFG_XRAM_LO];
    next_st.out.bank_select = next_st.program_status_word[PSW_BANK_HI:PSW_BANK_LO];
    next_st.out.data_pointer_value = {next_st.data_pointer_high, next_st.data_pointer_low};
    next_st.out.stack_address = {next_st.stack_pointer_high[SPH_ADDR_HI:0], next_st.spl};
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st.program_status_word <= RST_PROGRAM_STATUS_WORD;
      st.program_control <= RST_PROGRAM_CONTROL;
      st.data_pointer_low <= RST_DATA_POINTER;
      st.data_pointer_high <= RST_DATA_POINTER;
      st.spl <= RST_STACK_POINTER_LOW;
      st.stack_pointer_high <= RST_STACK_POINTER_HIGH;
      st.sbc <= RST_STACK_BOUNDARY_CONTROL;
      st.cfg <= RST_CORE_CONFIGURATION;
      st.rdata <= 8'h00;
      st.out.baud_doubler <= 1'b0;
      st.out.enhanced_uart_enable <= 1'b0;
      st.out.shared_serial_select <= 1'b0;
      st.out.carrier_modulation_enable <= 1'b0;
      st.out.xram_access_enable <= 1'b1;
      st.out.bank_select <= 2'h0;
      st.out.data_pointer_value <= 16'h0000;
      st.out.stack_address <= 11'h100;
      st.irq <= 1'b0;
      st.rst <= 1'b0;
    end
    else if (i_ce)
    begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_cfg = st.out;
  assign o_violation_irq = st.irq;
  assign o_violation_rst = st.rst;

  // ==========================================================
  // Checks
  chk_parity_even: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    i_ce |=> ((^$past(i_acc)) ^ st.program_status_word[PSW_PARITY]) == 1'b0)
    else $error("parity bit not even");
  chk_bank_out: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_cfg.bank_select == st.program_status_word[4:3])
    else $error("bank select mismatch");
  chk_data_pointer_word_word: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_cfg.data_pointer_value == {st.data_pointer_high, st.data_pointer_low})
    else $error("data pointer word mismatch");
  chk_carry_update: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_alu.op == CSSCR_OP_SUBB) |=> st.program_status_word[PSW_CARRY] == $past(i_alu.carry))
    else $error("carry not updated");
  chk_no_resp_off: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && !st.sbc[SBC_PROTECT_EN]) |=> !o_violation_irq && !o_violation_rst)
    else $error("violation while disabled");
  chk_bottom_ignore: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && st.sbc[SBC_PROTECT_EN] && i_bus.wr && i_bus.addr == ADDR_STACK_POINTER_LOW
     && {st.stack_pointer_high[2:0], i_bus.wdata} < start_addr)
    |=> $stable(st.spl) && st.stack_pointer_high[SPH_BOTTOM_FLAG])
    else $error("bottom write not ignored");
  chk_water_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && st.sbc[7:3] == 5'h00 && !below_start) |=> !o_violation_irq && !o_violation_rst)
    else $error("waterline response with zero setting");
  chk_xram_enable: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_cfg.xram_access_enable == (st.cfg[1] | st.cfg[0]))
    else $error("xram enable mismatch");
  chk_stack_wrap: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && !i_bus.wr && i_stk.push && cur_sp == STACK_TOP && !st.sbc[SBC_PROTECT_EN])
    |=> cur_sp == $past(start_addr))
    else $error("stack did not wrap");
  chk_overflow_update: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_alu.op != CSSCR_OP_NONE) |=> st.program_status_word[PSW_OVERFLOW] == $past(i_alu.overflow))
    else $error("overflow not updated");
  chk_aux_kept: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && !i_bus.wr && (i_alu.op == CSSCR_OP_SUBB || i_alu.op == CSSCR_OP_MUL
     || i_alu.op == CSSCR_OP_DIV)) |=> $stable(st.program_status_word[PSW_AUX_CARRY]))
    else $error("aux carry changed by subtract, multiply or divide");
  chk_user_flags: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_bus.wr && i_bus.addr == ADDR_PROGRAM_STATUS_WORD)
    |=> st.program_status_word[PSW_USER_ZERO] == $past(i_bus.wdata[PSW_USER_ZERO])
    && st.program_status_word[PSW_USER_ONE] == $past(i_bus.wdata[PSW_USER_ONE]))
    else $error("user flag write lost");
  chk_response_route: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && st.sbc[SBC_PROTECT_EN] && cand_valid && below_start)
    |=> o_violation_rst == $past(st.sbc[SBC_INT_RESET_SEL])
    && o_violation_irq == !$past(st.sbc[SBC_INT_RESET_SEL]))
    else $error("violation routed to wrong output");
  chk_water_flag: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && st.sbc[SBC_PROTECT_EN] && cand_valid && at_water && !below_start)
    |=> st.sbc[SBC_WATER_FLAG] && (o_violation_irq || o_violation_rst))
    else $error("waterline crossing not reported");
  chk_bottom_sticky: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && st.stack_pointer_high[SPH_BOTTOM_FLAG]
     && !(i_bus.wr && i_bus.addr == ADDR_STACK_POINTER_HIGH)) |=> st.stack_pointer_high[SPH_BOTTOM_FLAG])
    else $error("stack bottom flag lost");
  chk_ce_freeze: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !i_ce |=> $stable(o_cfg.data_pointer_value))
    else $error("data pointer moved while clock disabled");
  chk_data_pointer_word_high: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_bus.wr && i_bus.addr == ADDR_DATA_POINTER_HIGH)
    |=> o_cfg.data_pointer_value[15:8] == $past(i_bus.wdata))
    else $error("data pointer high byte not taken");
  chk_serial_select: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_bus.wr && i_bus.addr == ADDR_CORE_CONFIGURATION)
    |=> o_cfg.shared_serial_select == $past(i_bus.wdata[CFG_SHARED_SERIAL]))
    else $error("shared serial select not taken");
  chk_baud_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_bus.wr && i_bus.addr == ADDR_PROGRAM_CONTROL)
    |=> o_cfg.baud_doubler == $past(i_bus.wdata[PROGRAM_CONTROL_BAUD_DOUBLER]))
    else $error("baud doubler not taken");
  chk_start_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && i_bus.wr && i_bus.addr == ADDR_STACK_POINTER_HIGH)
    |=> st.stack_pointer_high[SPH_START_HI:SPH_START_LO] == $past(i_bus.wdata[SPH_START_HI:SPH_START_LO]))
    else $error("stack start bits not taken");
  chk_stack_pop: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_ce && !i_bus.wr && !i_stk.push && i_stk.pop && !st.sbc[SBC_PROTECT_EN])
    |=> cur_sp == 11'($past(cur_sp) - 11'h001))
    else $error("stack pop did not decrement");
endmodule
`default_nettype wire

/* File: hdl/csscr_pkg.sv */
// Package for the core status, stack and configuration register set.
// Assumes a single system clock domain and direct byte addressing by the core.
`default_nettype none
package csscr_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_STACK_POINTER_LOW = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PROGRAM_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_CORE_CONFIGURATION = 8'hAF;
  localparam logic [7:0] ADDR_STACK_POINTER_HIGH = 8'hB7;
  localparam logic [7:0] ADDR_STACK_BOUNDARY_CONTROL = 8'hBF;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hD0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_STACK_POINTER_LOW = 8'h00;
  localparam logic [7:0] RST_DATA_POINTER = 8'h00;
  localparam logic [7:0] RST_PROGRAM_CONTROL = 8'h00;
  localparam logic [7:0] RST_CORE_CONFIGURATION = 8'h81;
  localparam logic [7:0] RST_STACK_POINTER_HIGH = 8'h89;
  localparam logic [7:0] RST_STACK_BOUNDARY_CONTROL = 8'h00;
  localparam logic [7:0] RST_PROGRAM_STATUS_WORD = 8'h00;
  // ==========================================================
  // Field positions
  localparam int PSW_CARRY = 7;
  localparam int PSW_AUX_CARRY = 6;
  localparam int PSW_USER_ZERO = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_OVERFLOW = 2;
  localparam int PSW_USER_ONE = 1;
  localparam int PSW_PARITY = 0;
  localparam int PROGRAM_CONTROL_BAUD_DOUBLER = 7;
  localparam int SPH_BOTTOM_FLAG = 6;
  localparam int SPH_START_HI = 5;
  localparam int SPH_START_LO = 3;
  localparam int SPH_ADDR_HI = 2;
  localparam int SBC_WATER_HI = 7;
  localparam int SBC_WATER_LO = 3;
  localparam int SBC_INT_RESET_SEL = 2;
  localparam int SBC_PROTECT_EN = 1;
  localparam int SBC_WATER_FLAG = 0;
  localparam int CFG_ENH_UART = 6;
  localparam int CFG_SHARED_SERIAL = 5;
  localparam int CFG_CARRIER_MOD = 4;
  localparam int CFG_XRAM_HI = 1;
  localparam int CFG_XRAM_LO = 0;
  localparam logic [10:0] STACK_TOP = 11'h7FF;
  // ==========================================================
  // Carriers
  typedef enum logic [2:0] {
    CSSCR_OP_NONE, CSSCR_OP_ADD, CSSCR_OP_ADDC, CSSCR_OP_SUBB, CSSCR_OP_MUL, CSSCR_OP_DIV
  } csscr_op_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csscr_bus_t;
  typedef struct packed {
    csscr_op_t op;
    logic carry;
    logic aux_carry;
    logic overflow;
  } csscr_alu_t;
  typedef struct packed {
    logic push;
    logic pop;
  } csscr_stk_t;
  typedef struct packed {
    logic baud_doubler;
    logic enhanced_uart_enable;
    logic shared_serial_select;
    logic carrier_modulation_enable;
    logic xram_access_enable;
    logic [1:0] bank_select;
    logic [15:0] data_pointer_value;
    logic [10:0] stack_address;
  } csscr_cfg_t;
endpackage
`default_nettype wire

/* File: hdl/csscr_parity.sv */
// Even-parity generator for the accumulator.
// Assumes the accumulator value is presented every cycle.
`default_nettype none
module csscr_parity #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_data,
  output logic o_parity
);
  // Parity bit plus ones count is even
  assign o_parity = ^i_data;
endmodule
`default_nettype wire

/* File: hdl/csscr_stack_guard.sv */
// Stack boundary checks: bottom and waterline comparison.
// Assumes the caller gates results with the protection enable.
`default_nettype none
module csscr_stack_guard (
  input wire logic [10:0] i_candidate,
  input wire logic [2:0] i_start_bits,
  input wire logic [4:0] i_water_setting,
  output logic o_below_start,
  output logic o_at_waterline
);
  import csscr_pkg::*;
  logic [10:0] start_addr;
  logic [10:0] water_addr;
  assign start_addr = {i_start_bits, 8'h00};
  assign water_addr = STACK_TOP - {6'h00, i_water_setting};
  assign o_below_start = i_candidate < start_addr;
  // Zero setting disables the waterline
  assign o_at_waterline = (i_water_setting != 5'h00) && (i_candidate >= water_addr);
endmodule
`default_nettype wire

/* File: bench/csscr_core_model.sv */
// Core-side model: register accesses, ALU flag results, stack pulses, accumulator.
// Assumes every task is entered just after a rising edge of i_mclk.
`default_nettype none
module csscr_core_model (
  input wire logic i_mclk,
  output csscr_pkg::csscr_bus_t o_bus,
  output csscr_pkg::csscr_alu_t o_alu,
  output csscr_pkg::csscr_stk_t o_stk,
  output logic [7:0] o_acc
);
  timeunit 1ns;
  timeprecision 1ps;
  import csscr_pkg::*;

  initial
  begin
    o_bus = '0;
    o_alu = '{op: CSSCR_OP_NONE, carry: 1'b0, aux_carry: 1'b0, overflow: 1'b0};
    o_stk = '0;
    o_acc = 8'h00;
  end

  // ==========================================================
  // Access tasks
  task automatic sel(input logic [7:0] a);
    o_bus.addr = a;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_bus = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge i_mclk);
    #1;
    o_bus.wr = 1'b0;
    // Released data no longer shows the last value
    o_bus.wdata = ~d;
  endtask

  task automatic alu(input csscr_op_t op, input logic [2:0] f);
    o_alu = '{op: op, carry: f[2], aux_carry: f[1], overflow: f[0]};
    @(posedge i_mclk);
    #1;
    o_alu.op = CSSCR_OP_NONE;
    {o_alu.carry, o_alu.aux_carry, o_alu.overflow} = ~f;
  endtask

  task automatic step(input logic up);
    o_stk = '{push: up, pop: !up};
    @(posedge i_mclk);
    #1;
    o_stk = '0;
  endtask
endmodule
`default_nettype wire

/* File: bench/csscr_regs_bench.sv */
// Testbench for the status, stack and configuration register set.
// Assumes the core model drives all requests just after a rising edge.
`default_nettype none
module csscr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import csscr_pkg::*;

  logic i_mclk;
  logic i_arst_n;
  logic i_ce;
  csscr_bus_t bus;
  csscr_alu_t alu;
  csscr_stk_t stk;
  logic [7:0] acc;
  logic [7:0] rdata;
  csscr_cfg_t cfg;
  logic irq;
  logic rst_pulse;
  int fail_count;
  int checks_done;
  int cycles;
  logic [7:0] ra [9] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hAF, 8'hB7, 8'hBF, 8'hD0, 8'h90};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h89, 8'h00, 8'h00, 8'h00};
  logic [7:0] wa [6] = '{8'hAF, 8'hAF, 8'h87, 8'hAF, 8'h87, 8'h90};
  logic [7:0] wd [6] = '{8'hF0, 8'h82, 8'h80, 8'hA1, 8'h00, 8'hFF};
  logic [7:0] wx [6] = '{8'hF0, 8'h82, 8'h80, 8'hA1, 8'h00, 8'h00};
  logic [4:0] wc [6] = '{5'h0E, 5'h01, 5'h11, 5'h15, 5'h05, 5'h05};
  csscr_op_t ops [6] = '{CSSCR_OP_ADD, CSSCR_OP_SUBB, CSSCR_OP_MUL, CSSCR_OP_DIV,
    CSSCR_OP_ADDC, CSSCR_OP_NONE};
  logic [2:0] fl [6] = '{3'h7, 3'h0, 3'h5, 3'h2, 3'h1, 3'h7};
  logic [7:0] px [6] = '{8'hC4, 8'h40, 8'hC4, 8'h40, 8'h04, 8'h04};
  logic [7:0] bc [4] = '{8'h0A, 8'h0E, 8'h02, 8'hF8};
  logic [1:0] bp [4] = '{2'h2, 2'h1, 2'h0, 2'h0};

  csscr_regs u_csscr_regs (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_bus(bus),
    .i_alu(alu),
    .i_stk(stk),
    .i_acc(acc),
    .o_rdata(rdata),
    .o_cfg(cfg),
    .o_violation_irq(irq),
    .o_violation_rst(rst_pulse)
  );

  csscr_core_model u_csscr_core_model (
    .i_mclk(i_mclk),
    .o_bus(bus),
    .o_alu(alu),
    .o_stk(stk),
    .o_acc(acc)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_csscr_core_model.sel(a);
    @(posedge i_mclk);
    #1;
    chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    i_arst_n = 1'b0;
    i_ce = 1'b1;
    repeat (5) @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    foreach (ra[k]) rd(ra[k], rv[k]);
    chk("stack", {5'h00, cfg.stack_address}, 16'h0100);
    chk("xram", {15'h0000, cfg.xram_access_enable}, 16'h0001);
    $display("Test reset values done");
    // Reserved bits kept as required
    for (int k = 0; k < 6; k++)
    begin
      u_csscr_core_model.wr(wa[k], wd[k]);
      rd(wa[k], wx[k]);
      chk("cfg", {11'h000, cfg.baud_doubler, cfg.enhanced_uart_enable,
        cfg.shared_serial_select, cfg.carrier_modulation_enable,
        cfg.xram_access_enable}, {11'h000, wc[k]});
    end
    u_csscr_core_model.wr(8'h82, 8'h34);
    u_csscr_core_model.wr(8'h83, 8'h12);
    chk("data_pointer_word", cfg.data_pointer_value, 16'h1234);
    i_ce = 1'b0;
    u_csscr_core_model.wr(8'h82, 8'h55);
    i_ce = 1'b1;
    chk("data_pointer_word frozen", cfg.data_pointer_value, 16'h1234);
    $display("Test configuration done");
    for (int b = 0; b < 4; b++)
    begin
      u_csscr_core_model.wr(8'hD0, 8'h22 | 8'(b << 3));
      rd(8'hD0, 8'h22 | 8'(b << 3));
      chk("bank", {14'h0000, cfg.bank_select}, 16'(b));
    end
    u_csscr_core_model.wr(8'hD0, 8'h01);
    rd(8'hD0, 8'h00);
    u_csscr_core_model.o_acc = 8'h07;
    @(posedge i_mclk);
    rd(8'hD0, 8'h01);
    u_csscr_core_model.o_acc = 8'h03;
    @(posedge i_mclk);
    rd(8'hD0, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      u_csscr_core_model.alu(ops[k], fl[k]);
      rd(8'hD0, px[k]);
    end
    $display("Test status word done");
    u_csscr_core_model.wr(8'hB7, 8'h8F);
    u_csscr_core_model.wr(8'h81, 8'hFF);
    chk("stack", {5'h00, cfg.stack_address}, 16'h07FF);
    u_csscr_core_model.step(1'b1);
    chk("stack wrap", {5'h00, cfg.stack_address}, 16'h0100);
    rd(8'hB7, 8'h89);
    u_csscr_core_model.step(1'b0);
    chk("stack pop", {5'h00, cfg.stack_address}, 16'h00FF);
    u_csscr_core_model.wr(8'hBF, 8'h02);
    u_csscr_core_model.wr(8'hB7, 8'hB7);
    u_csscr_core_model.wr(8'hB7, 8'hB1);
    chk("stack kept", {5'h00, cfg.stack_address}, 16'h07FF);
    rd(8'hB7, 8'hF7);
    rd(8'hB7, 8'hF7);
    u_csscr_core_model.wr(8'hB7, 8'hB7);
    rd(8'hB7, 8'hB7);
    $display("Test stack bottom done");
    for (int k = 0; k < 4; k++)
    begin
      u_csscr_core_model.wr(8'h81, 8'hFD);
      u_csscr_core_model.wr(8'hBF, bc[k]);
      u_csscr_core_model.step(1'b1);
      chk("pulses", {14'h0000, irq, rst_pulse}, {14'h0000, bp[k]});
      chk("stack", {5'h00, cfg.stack_address}, 16'h07FE);
      rd(8'hBF, bc[k] | {7'h00, |bp[k]});
      chk("pulse end", {14'h0000, irq, rst_pulse}, 16'h0000);
    end
    $display("Test waterline done");
    u_csscr_core_model.wr(8'hB7, 8'hB5);
    u_csscr_core_model.wr(8'hBF, 8'h02);
    u_csscr_core_model.wr(8'h81, 8'h10);
    chk("bottom pulse", {14'h0000, irq, rst_pulse}, 16'h0002);
    chk("stack low kept", {5'h00, cfg.stack_address}, 16'h05FE);
    rd(8'hB7, 8'hF5);
    $display("Test stack low write done");
    i_arst_n = 1'b0;
    #1;
    chk("rdata in reset", {8'h00, rdata}, 16'h0000);
    chk("stack in reset", {5'h00, cfg.stack_address}, 16'h0100);
    @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    rd(8'hBF, 8'h00);
    $display("Test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
